// [core/pri_arbiter.sv]
/*
  Combinational selection of the highest-priority eligible source.
  Assumes the caller registers its outputs.
*/
`timescale 1ns/1ps
module pri_arbiter #(
  parameter int NSRC = 5,
  parameter int IDX_W = 3
) (
  input wire logic [NSRC-1:0] pend,
  input wire logic [NSRC*3-1:0] prio,
  input wire logic [3:0] cur_level,
  output logic valid,
  output logic [IDX_W-1:0] idx,
  output logic [2:0] level
);

  always_comb
  begin
    logic [2:0] p;
    valid = 1'b0;
    idx = '0;
    level = '0;
    p = '0;
    // Lower index wins a tie, hence the downward walk with >=
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      p = prio[i*3 +: 3];
      if (pend[i] && (p != 3'h0) && ({1'b0, p} > cur_level) && (!valid || p >= level)) // [RQ11] [RQ19]
      begin
        valid = 1'b1;
        idx = IDX_W'(i);
        level = p;
      end
    end
  end

endmodule : pri_arbiter

// [core/pri_interrupt_control.sv]
/*
  Priority interrupt control slice: CPU priority level, request flags,
  enables, priority fields, capture register and level stack, reached
  over AHB-Lite.
  Assumes peripheral request lines are one-cycle pulses on clk, external
  pins are asynchronous, and the core acknowledges on clk.
*/
//
// Behaviour
// [RQ1] Level is msb bit above three status bits
// [RQ2] Msb priority bit read-only to software
// [RQ3] Accepted request latches vector and level
// [RQ4] Status bits 7..5 hold level; 7 blocks users
// [RQ5] Msb set maps codes to levels 8..15
// [RQ6] Status level bits read-only when nesting disabled
// [RQ7] Status bits 15..9 read zero, ignore writes
// [RQ8] Flag bit positions 14, 6, 5, 2, 1
// [RQ9] Flags hardware-set, software read/write, reset zero
// [RQ10] Two-wire priorities at bits 10..8 and 6..4
// [RQ11] Priority 111 highest, 000 disables source
// [RQ12] Priority fields reset to level four
// [RQ13] No preemption while nesting disabled
// [RQ14] Software: mode, priority, clear flag, enable
// [RQ15] Software clears flag before enabling source
// [RQ16] Software may give all sources equal priority
// [RQ17] Service routine clears its flag before return
// [RQ18] Traps at levels 8..15 never masked
// [RQ19] Request needs flag, enable, priority above level
`timescale 1ns/1ps
module pri_interrupt_control #(
  parameter int STACK_DEPTH = 4,
  parameter logic [6:0] VEC_BASE = 7'h08 // Arbitrary vector base
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic calendar_clock_req,
  input wire logic external_pin_four,
  input wire logic external_pin_three,
  input wire logic two_wire_b_master_req,
  input wire logic two_wire_b_slave_req,
  input wire logic core_ack,
  input wire logic core_return,
  input wire logic trap_enter,
  input wire logic [pri_pkg::PRIO_W-1:0] trap_level,
  output logic core_req,
  output logic [pri_pkg::CAP_VEC_W-1:0] core_vector,
  output logic [pri_pkg::LVL_W-1:0] core_level,
  output logic irq_out
);
  import pri_pkg::*;

  localparam int IDX_W = 3;
  localparam int PTR_W = $clog2(STACK_DEPTH + 1);

  // Bus pipeline state
  logic wr_pend_reg;
  logic [OFS_W-1:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [OFS_W-1:0] rd_addr_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;

  // Block state
  logic [PRIO_W-1:0] lvl_bits_reg;
  logic msb_reg;
  logic nest_dis_reg;
  logic [NSRC-1:0] flag_reg;
  logic [NSRC-1:0] en_reg;
  pri_prio_t prio_reg [NSRC];
  logic [CAP_VEC_W-1:0] cap_vec_reg;
  pri_level_t cap_lvl_reg;
  logic [EVT_W-1:0] evt_stat_reg;
  logic [EVT_W-1:0] evt_en_reg;
  pri_level_t stack_reg [STACK_DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic core_req_reg;
  logic [CAP_VEC_W-1:0] core_vector_reg;
  pri_level_t core_level_reg;
  logic irq_reg;

  // Address phase decode
  wire addr_ok = hsel & htrans[1] & hready;
  wire wr_start = addr_ok & hwrite;
  wire rd_start = addr_ok & ~hwrite;
  wire [OFS_W-1:0] a_ofs = haddr[OFS_W-1:0];

  // Data phase write strobes
  wire [REG_W-1:0] wd = hwdata[REG_W-1:0];
  wire wr_status = wr_pend_reg && (wr_addr_reg == OFS_STATUS);
  wire wr_ictl = wr_pend_reg && (wr_addr_reg == OFS_ICTL);
  wire wr_flags = wr_pend_reg && (wr_addr_reg == OFS_FLAGS);
  wire wr_enable = wr_pend_reg && (wr_addr_reg == OFS_ENABLE);
  wire wr_prio12 = wr_pend_reg && (wr_addr_reg == OFS_PRIO12);
  wire wr_priox = wr_pend_reg && (wr_addr_reg == OFS_PRIOX);
  wire wr_evt_clr = wr_pend_reg && (wr_addr_reg == OFS_EVT_CLR);
  wire wr_evt_en = wr_pend_reg && (wr_addr_reg == OFS_EVT_EN);

  // Request sources
  logic [1:0] pin_rise;
  pri_pin_sync #(
    .W(2)
  ) pri_pin_sync_i (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({external_pin_four, external_pin_three}),
    .rise(pin_rise)
  );

  wire [NSRC-1:0] set_pulse = {two_wire_b_slave_req, two_wire_b_master_req,
                               pin_rise[0], pin_rise[1], calendar_clock_req};

  // Current level: msb above the three status bits
  wire [LVL_W-1:0] cur_level = {msb_reg, lvl_bits_reg}; // [RQ1] [RQ5]
  wire in_service = (ptr_reg != '0);
  wire [LVL_W-1:0] stack_top = stack_reg[ptr_reg == '0 ? 0 : 32'(ptr_reg) - 1];

  // Arbitration over flagged and enabled sources
  logic [NSRC*3-1:0] prio_flat;
  logic arb_valid;
  logic [IDX_W-1:0] arb_idx;
  logic [PRIO_W-1:0] arb_level;

  pri_arbiter #(
    .NSRC(NSRC),
    .IDX_W(IDX_W)
  ) pri_arbiter_i (
    .pend(flag_reg & en_reg), // [RQ19]
    .prio(prio_flat),
    .cur_level(cur_level), // [RQ18]
    .valid(arb_valid),
    .idx(arb_idx),
    .level(arb_level)
  );

  // Level changes, in order of precedence: trap, accept, return, software write
  wire accept = core_ack & core_req_reg & ~trap_enter;
  wire pop = core_return & in_service & ~trap_enter & ~accept;
  wire push = trap_enter | accept;
  wire sw_level = wr_status & ~nest_dis_reg; // [RQ6]

  wire [PRIO_W-1:0] lvl_bits_next = trap_enter ? trap_level :
                                    accept ? core_level_reg[PRIO_W-1:0] :
                                    pop ? stack_top[PRIO_W-1:0] :
                                    sw_level ? wd[LEVEL_LSB +: PRIO_W] : lvl_bits_reg; // [RQ4]
  // Only traps and returns move the msb; no bus path reaches it
  wire msb_next = trap_enter ? 1'b1 : pop ? stack_top[MSB_BIT] : msb_reg; // [RQ2] [RQ18]

  // While nesting is off, a user request cannot preempt a running routine
  wire req_next = arb_valid & ~(nest_dis_reg & in_service) & ~push; // [RQ13]

  // Flags, enables and priority fields per source
  logic [NSRC-1:0] flag_next;
  logic [NSRC-1:0] en_next;
  pri_prio_t prio_next [NSRC];
  logic [REG_W-1:0] flags_word;
  logic [REG_W-1:0] enable_word;
  logic [REG_W-1:0] prio12_word;
  logic [REG_W-1:0] priox_word;

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_src
      // A hardware set in the clearing cycle still lands
      assign flag_next[gi] = (wr_flags ? wd[FLAG_POS[gi]] : flag_reg[gi])
                             | set_pulse[gi]; // [RQ8] [RQ9]
      assign en_next[gi] = wr_enable ? wd[FLAG_POS[gi]] : en_reg[gi];
      assign prio_next[gi] = ((PRIO_IN_12[gi] && wr_prio12) || (!PRIO_IN_12[gi] && wr_priox))
                             ? wd[PRIO_LSB[gi] +: PRIO_W] : prio_reg[gi]; // [RQ10]
      assign prio_flat[gi*3 +: 3] = prio_reg[gi];
    end
  endgenerate

  function automatic logic [REG_W-1:0] pack_bits(input logic [NSRC-1:0] v);
    logic [REG_W-1:0] r;
    r = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      r[FLAG_POS[i]] = v[i];
    end
    return r;
  endfunction : pack_bits

  function automatic logic [REG_W-1:0] pack_prio(input logic in12, input logic [NSRC*3-1:0] p);
    logic [REG_W-1:0] r;
    r = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (PRIO_IN_12[i] == in12)
      begin
        r[PRIO_LSB[i] +: PRIO_W] = p[i*3 +: 3];
      end
    end
    return r;
  endfunction : pack_prio

  assign flags_word = pack_bits(flag_reg);
  assign enable_word = pack_bits(en_reg);
  assign prio12_word = pack_prio(1'b1, prio_flat);
  assign priox_word = pack_prio(1'b0, prio_flat);

  // Events: sticky, set wins over clear
  wire [EVT_W-1:0] evt_set = {|(set_pulse & ~flag_reg), trap_enter, accept};
  wire [EVT_W-1:0] evt_clr = wr_evt_clr ? wd[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] evt_stat_next = (evt_stat_reg & ~evt_clr) | evt_set;
  wire [EVT_W-1:0] evt_en_next = wr_evt_en ? wd[EVT_W-1:0] : evt_en_reg;

  // Read mux; unmapped and write-only words read zero
  wire [REG_W-1:0] status_word = {7'h00, 1'b0, lvl_bits_reg, 5'h00}; // [RQ7]
  wire [REG_W-1:0] core_word = REG_W'({msb_reg, 3'h0});
  wire [REG_W-1:0] ictl_word = {nest_dis_reg, 15'h0000};
  wire [REG_W-1:0] cap_word = {4'h0, cap_lvl_reg, 1'b0, cap_vec_reg};
  wire [REG_W-1:0] rd_word =
    (rd_addr_reg == OFS_STATUS) ? status_word :
    (rd_addr_reg == OFS_CORE) ? core_word :
    (rd_addr_reg == OFS_ICTL) ? ictl_word :
    (rd_addr_reg == OFS_FLAGS) ? flags_word :
    (rd_addr_reg == OFS_ENABLE) ? enable_word :
    (rd_addr_reg == OFS_PRIO12) ? prio12_word :
    (rd_addr_reg == OFS_PRIOX) ? priox_word :
    (rd_addr_reg == OFS_CAPTURE) ? cap_word :
    (rd_addr_reg == OFS_EVT_STAT) ? REG_W'(evt_stat_reg) :
    (rd_addr_reg == OFS_EVT_EN) ? REG_W'(evt_en_reg) : 16'h0000;

  // Bus slave. Reads take one wait state so a write in the preceding
  // data phase is already visible to them.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= wr_start;
      rd_pend_reg <= rd_start;
      if (addr_ok)
      begin
        wr_addr_reg <= a_ofs;
        rd_addr_reg <= a_ofs;
      end
      hready_reg <= ~rd_start;
      if (rd_pend_reg)
      begin
        hrdata_reg <= {16'h0000, rd_word};
      end
    end
  end

  // Level, nesting mode and capture
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lvl_bits_reg <= '0;
      msb_reg <= 1'b0;
      nest_dis_reg <= 1'b0;
      cap_vec_reg <= '0;
      cap_lvl_reg <= '0;
    end
    else
    begin
      lvl_bits_reg <= lvl_bits_next;
      msb_reg <= msb_next;
      if (wr_ictl)
      begin
        nest_dis_reg <= wd[NEST_DIS_BIT];
      end
      if (accept)
      begin
        cap_vec_reg <= core_vector_reg; // [RQ3]
        cap_lvl_reg <= core_level_reg; // [RQ3]
      end
    end
  end

  // Saved levels; a push beyond the depth overwrites the top entry
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ptr_reg <= '0;
    end
    else if (push)
    begin
      stack_reg[ptr_reg == PTR_W'(STACK_DEPTH) ? STACK_DEPTH - 1 : 32'(ptr_reg)] <= cur_level;
      if (ptr_reg != PTR_W'(STACK_DEPTH))
      begin
        ptr_reg <= ptr_reg + PTR_W'(1);
      end
    end
    else if (pop)
    begin
      ptr_reg <= ptr_reg - PTR_W'(1);
    end
  end

  // Source registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      flag_reg <= '0; // [RQ9]
      en_reg <= '0;
      for (int i = 0; i < NSRC; i++)
      begin
        prio_reg[i] <= PRIO_RST; // [RQ12]
      end
    end
    else
    begin
      flag_reg <= flag_next;
      en_reg <= en_next;
      prio_reg <= prio_next;
    end
  end

  // Core side and interrupt output
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      core_req_reg <= 1'b0;
      core_vector_reg <= '0;
      core_level_reg <= '0;
      evt_stat_reg <= '0;
      evt_en_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      core_req_reg <= req_next;
      core_vector_reg <= VEC_BASE + CAP_VEC_W'(arb_idx);
      core_level_reg <= {1'b0, arb_level};
      evt_stat_reg <= evt_stat_next;
      evt_en_reg <= evt_en_next;
      irq_reg <= |(evt_stat_next & evt_en_next);
    end
  end

  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign core_req = core_req_reg;
  assign core_vector = core_vector_reg;
  assign core_level = core_level_reg;
  assign irq_out = irq_reg;

endmodule : pri_interrupt_control

// [core/pri_pin_sync.sv]
/*
  Two-flop synchroniser with rising-edge pulse for external request pins.
  Assumes pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module pri_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] rise
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Edge taken from the settled stages only
  assign rise = s2_reg & ~s3_reg;

endmodule : pri_pin_sync

// [core/pri_pkg.sv]
/*
  Shared constants of the priority interrupt controller: register offsets,
  field positions, reset values and source layout.
  Assumes a 32-bit AHB-Lite bus with registers on aligned words.
*/
package pri_pkg;

  localparam int NSRC = 5;
  localparam int REG_W = 16;
  localparam int OFS_W = 8;

  // Word offsets on the bus
  localparam logic [OFS_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [OFS_W-1:0] OFS_CORE = 8'h04;
  localparam logic [OFS_W-1:0] OFS_ICTL = 8'h08;
  localparam logic [OFS_W-1:0] OFS_FLAGS = 8'h0C;
  localparam logic [OFS_W-1:0] OFS_ENABLE = 8'h10;
  localparam logic [OFS_W-1:0] OFS_PRIO12 = 8'h14;
  localparam logic [OFS_W-1:0] OFS_PRIOX = 8'h18;
  localparam logic [OFS_W-1:0] OFS_CAPTURE = 8'h1C;
  localparam logic [OFS_W-1:0] OFS_EVT_STAT = 8'h20;
  localparam logic [OFS_W-1:0] OFS_EVT_CLR = 8'h24;
  localparam logic [OFS_W-1:0] OFS_EVT_EN = 8'h28;

  // Status word, core control and control one fields
  localparam int LEVEL_LSB = 5;
  localparam int PRIO_W = 3;
  localparam int LVL_W = 4;
  localparam int MSB_BIT = 3;
  localparam int NEST_DIS_BIT = 15;

  // Sources: 0 calendar, 1 pin four, 2 pin three, 3 two-wire master, 4 slave
  localparam int FLAG_POS [NSRC] = '{14, 6, 5, 2, 1};
  localparam bit PRIO_IN_12 [NSRC] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  localparam int PRIO_LSB [NSRC] = '{0, 4, 8, 8, 4};
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h4;
  localparam int PIN_FOUR = 1;
  localparam int PIN_THREE = 2;

  // Capture register layout
  localparam int CAP_VEC_LSB = 0;
  localparam int CAP_VEC_W = 7;
  localparam int CAP_LVL_LSB = 8;

  // Event status bits
  localparam int EVT_W = 3;
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_TRAP = 1;
  localparam int EVT_FLAG = 2;

  typedef logic [PRIO_W-1:0] pri_prio_t;
  typedef logic [LVL_W-1:0] pri_level_t;

endpackage : pri_pkg

// [verif/pri_core_model.sv]
/*
  Behavioural processor core: accepts a presented request after a chosen
  delay and returns from the routine when the bench says it is done.
*/
`timescale 1ns/1ps
module pri_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic core_req,
  input wire logic [1:0] ack_delay,
  input wire logic done,
  output logic core_ack,
  output logic core_return
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wait_reg <= 2'h0;
      core_ack <= 1'b0;
      core_return <= 1'b0;
    end
    else
    begin
      // One-cycle ack so the sampling edge still sees the request
      core_ack <= core_req && !core_ack && wait_reg >= ack_delay;
      wait_reg <= (core_req && !core_ack) ? wait_reg + 2'h1 : 2'h0;
      core_return <= done;
    end
  end
endmodule : pri_core_model

// [verif/pri_props.sv]
/*
  Port assertions of the priority interrupt controller.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pri_props #(
  parameter logic [6:0] VEC_BASE = 7'h08
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic core_ack,
  input wire logic core_return,
  input wire logic trap_enter,
  input wire logic core_req,
  input wire logic [6:0] core_vector,
  input wire logic [3:0] core_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rd_take_s; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence wr_take_s; hsel && htrans[1] && hready && hwrite; endsequence
  sequence rd_wait_s; !hreadyout ##1 hreadyout; endsequence
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rd_wait_a: assert property (rd_take_s |=> rd_wait_s)
    else $error("read data phase not one wait");
  wr_nowait_a: assert property (wr_take_s |=> hreadyout)
    else $error("write data phase stalled");
  hrdata_hi_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  req_level_a: assert property (core_req |-> !core_level[3] && core_level[2:0] != 3'h0)
    else $error("presented level out of range");
  vec_range_a: assert property (core_req |-> core_vector >= VEC_BASE &&
    core_vector < VEC_BASE + 7'd5) else $error("vector out of range");
  ack_drop_a: assert property (core_req && core_ack && !trap_enter |=> !core_req)
    else $error("request held after accept");
  trap_mask_a: assert property (trap_enter ##1 !core_return |=> !core_req)
    else $error("user request during trap");
endmodule : pri_props

// [verif/tb_priority_interrupt_control.sv]
/*
  Self-checking bench: AHB-Lite master, core model, random levels.
  Assumes hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module tb_priority_interrupt_control;
  import pri_pkg::*;
  localparam logic [6:0] VB = 7'h08;
  logic clk, reset_n, hsel, hwrite, trap_enter, done, hresp, core_ack, core_return;
  logic core_req, irq_out;
  logic [31:0] haddr, hwdata, hrdata, rd, rs, r;
  logic [1:0] htrans, ack_delay;
  logic [2:0] hsize, trap_level, p, lv;
  logic [4:0] src;
  logic [6:0] core_vector;
  logic [3:0] core_level;
  wire hready;
  int num_errors, n_checks, cyc, k, i;
  pri_interrupt_control #(.VEC_BASE(VB)) pri_interrupt_control_i (.clk(clk),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .calendar_clock_req(src[0]),
    .external_pin_four(src[1]), .external_pin_three(src[2]),
    .two_wire_b_master_req(src[3]), .two_wire_b_slave_req(src[4]),
    .core_ack(core_ack), .core_return(core_return), .trap_enter(trap_enter),
    .trap_level(trap_level), .core_req(core_req), .core_vector(core_vector),
    .core_level(core_level), .irq_out(irq_out));
  pri_core_model pri_core_model_i (.clk(clk), .reset_n(reset_n), .core_req(core_req),
    .ack_delay(ack_delay), .done(done), .core_ack(core_ack), .core_return(core_return));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  function automatic logic [31:0] exp_cap(input int s, input logic [2:0] pr);
    return {20'h0_0000, 1'b0, pr, 1'b0, VB + 7'(s)};
  endfunction : exp_cap
  task finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : chk
  // Master holds each phase until hready is seen high at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc
  task pulse(input int s);
    src <= 5'h01 << s;
    @(posedge clk);
    src <= 5'h00;
    repeat (10) @(posedge clk);
  endtask : pulse
  task ret();
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : ret
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    rs = 32'h1c21_938a;
    {reset_n, hsel, hwrite, trap_enter, done, src, htrans, ack_delay, trap_level} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rdc(OFS_STATUS, 32'h0, "status");
    rdc(OFS_FLAGS, 32'h0, "flags");
    rdc(OFS_PRIO12, 32'h0000_0440, "prio12");
    rdc(OFS_PRIOX, 32'h0000_0444, "priox");
    wr(8'h2C, 32'hFFFF_FFFF);
    rdc(8'h2C, 32'h0, "unmapped");
    wr(OFS_CORE, 32'h0000_0008);
    rdc(OFS_CORE, 32'h0, "core ctl");
    for (k = 0; k < 4; k++)
    begin
      r = xs();
      wr(OFS_STATUS, r);
      rdc(OFS_STATUS, r & 32'h0000_00E0, "status rw");
      wr(OFS_FLAGS, r);
      rdc(OFS_FLAGS, r & 32'h0000_4066, "flags rw");
      wr(OFS_PRIO12, r);
      rdc(OFS_PRIO12, r & 32'h0000_0770, "prio12 rw");
    end
    wr(OFS_STATUS, 32'h0);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_EVT_EN, 32'h0000_0004);
    for (k = 0; k < NSRC; k++)
    begin
      pulse(k);
      rdc(OFS_FLAGS, 32'h1 << FLAG_POS[k], "hw flag");
      wr(OFS_FLAGS, 32'h0);
    end
    chk("irq set", 32'h1, 32'(irq_out));
    wr(OFS_EVT_EN, 32'h0);
    rdc(OFS_EVT_STAT, 32'h0000_0004, "event");
    chk("irq masked", 32'h0, 32'(irq_out));
    wr(OFS_EVT_CLR, 32'h0000_0004);
    rdc(OFS_EVT_STAT, 32'h0, "event clr");
    wr(OFS_ENABLE, 32'h0000_4066);
    for (k = 0; k < 12; k++)
    begin
      r = xs();
      i = int'(r[2:0]) % NSRC;
      p = (k < 2) ? 3'(7 * k) : r[6:4];
      lv = (k < 2) ? 3'(6 * k) : r[10:8];
      ack_delay <= r[13:12];
      wr(OFS_STATUS, {24'h00_0000, lv, 5'h00});
      wr(PRIO_IN_12[i] ? OFS_PRIO12 : OFS_PRIOX, 32'(p) << PRIO_LSB[i]);
      pulse(i);
      if (p > lv)
      begin
        rdc(OFS_CAPTURE, exp_cap(i, p), "capture");
        rdc(OFS_STATUS, {24'h00_0000, p, 5'h00}, "new level");
        wr(OFS_FLAGS, 32'h0);
        ret();
      end
      chk("no request", 32'h0, 32'(core_req));
      rdc(OFS_STATUS, {24'h00_0000, lv, 5'h00}, "level");
      wr(OFS_FLAGS, 32'h0);
    end
    wr(OFS_STATUS, 32'h0);
    wr(OFS_ICTL, 32'h0000_8000);
    wr(OFS_STATUS, 32'h0000_00E0);
    rdc(OFS_STATUS, 32'h0, "status ro");
    wr(OFS_PRIOX, 32'h0000_0003);
    wr(OFS_PRIO12, 32'h0000_0600);
    pulse(0);
    pulse(3);
    rdc(OFS_CAPTURE, exp_cap(0, 3'h3), "no preempt");
    wr(OFS_FLAGS, 32'h0000_0004);
    ret();
    rdc(OFS_CAPTURE, exp_cap(3, 3'h6), "after return");
    wr(OFS_FLAGS, 32'h0);
    ret();
    wr(OFS_ICTL, 32'h0);
    wr(OFS_PRIOX, 32'h0000_0007);
    trap_level <= 3'h2;
    trap_enter <= 1'b1;
    @(posedge clk);
    trap_enter <= 1'b0;
    pulse(0);
    rdc(OFS_CORE, 32'h0000_0008, "msb");
    rdc(OFS_STATUS, 32'h0000_0040, "trap level");
    chk("trap masks", 32'h0, 32'(core_req));
    ret();
    rdc(OFS_CAPTURE, exp_cap(0, 3'h7), "after trap");
    rdc(OFS_CORE, 32'h0, "msb back");
    wr(OFS_FLAGS, 32'h0);
    ret();
    // Equal non-zero priorities everywhere: the lower source index wins the tie
    wr(OFS_PRIOX, 32'h0000_0555);
    wr(OFS_PRIO12, 32'h0000_0550);
    src <= 5'h18;
    @(posedge clk);
    src <= 5'h00;
    repeat (10) @(posedge clk);
    rdc(OFS_CAPTURE, exp_cap(3, 3'h5), "equal tie");
    wr(OFS_FLAGS, 32'h0000_0002);
    ret();
    rdc(OFS_CAPTURE, exp_cap(4, 3'h5), "equal next");
    wr(OFS_FLAGS, 32'h0);
    ret();
    rdc(OFS_STATUS, 32'h0, "equal done");
    finish_test();
  end
endmodule : tb_priority_interrupt_control
bind pri_interrupt_control pri_props #(.VEC_BASE(VEC_BASE)) pri_props_i (.clk(clk),
  .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_ack(core_ack),
  .core_return(core_return), .trap_enter(trap_enter), .core_req(core_req),
  .core_vector(core_vector), .core_level(core_level));
